// [rtl/freq_ref_cfg.svh]
`ifndef FREQ_REF_CFG_SVH
`define FREQ_REF_CFG_SVH

// ==========================================================================
// Register offsets
// ==========================================================================
`define OFS_SOURCE_SEL    12'h000
`define OFS_PULSE_FUNC    12'h004
`define OFS_PULSE_SCALE   12'h008
`define OFS_AIN_CFG       12'h00C
`define OFS_OPERATOR_REF  12'h010
`define OFS_SERIAL_REF    12'h014
`define OFS_OPTION_REF    12'h018
`define OFS_JOG_REF       12'h01C
`define OFS_MULTI_BASE    12'h040
`define OFS_FREQ_REF      12'h080
`define OFS_PULSE_FREQ    12'h084
`define OFS_STATUS        12'h088

// ==========================================================================
// Reset values
// ==========================================================================
`define RST_SOURCE_SEL    3'h1
`define RST_PULSE_FUNC    2'h0
`define RST_PULSE_SCALE   16'h05A0
`define RST_AIN_SECOND_LVL 2'h0
`define RST_AIN_SECOND_FN 5'h1F
`define RST_AIN_THIRD_FN  5'h1F

// ==========================================================================
// Setting limits
// ==========================================================================
`define MAX_SOURCE_SEL    3'h4
`define MAX_PULSE_FUNC    2'h2
`define MIN_PULSE_SCALE   16'h03E8
`define MAX_PULSE_SCALE   16'h7D00

// ==========================================================================
// Field positions and codes in the analog configuration word
// ==========================================================================
`define AIN_LVL_LSB       0
`define AIN_SECOND_FN_LSB 8
`define AIN_THIRD_FN_LSB  16
`define AIN_LVL_CURRENT   2'h2
`define AIN_FN_ADD_FIRST  5'h00
`define AIN_FN_AUX        5'h02

// ==========================================================================
// Timing
// ==========================================================================
`define CLK_HZ            10000000
`define GATE_TIME_MS      100
`define GATE_CYCLES       ((`CLK_HZ / 1000) * `GATE_TIME_MS)

`endif

// [rtl/freq_ref_pkg.sv]
package freq_ref_pkg;

  typedef enum logic [2:0] {
    SRC_OPERATOR,
    SRC_ANALOG,
    SRC_SERIAL,
    SRC_OPTION,
    SRC_PULSE
  } ref_source_t;

  typedef enum logic [1:0] {
    PULSE_FREQ_REF,
    PULSE_PID_FEEDBACK,
    PULSE_PID_TARGET
  } pulse_func_t;

  typedef struct packed {
    logic [1:0] second_level;
    logic [4:0] second_func;
    logic [4:0] third_func;
  } ain_cfg_t;

  typedef struct packed {
    logic step1;
    logic step2;
    logic step3;
    logic jog;
  } step_inputs_t;

endpackage : freq_ref_pkg

// [rtl/pulse_scaler.sv]
`timescale 1ns/1ps
`default_nettype none
`include "freq_ref_cfg.svh"

module pulse_scaler
  import freq_ref_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = `GATE_CYCLES
)(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_pulse_sync,
  input  wire logic [15:0] i_scale_hz,
  output logic      [15:0] o_freq_hz,
  output logic      [15:0] o_percent_q14,
  output logic             o_update
);

  localparam int unsigned GATES_PER_SEC = 1000 / `GATE_TIME_MS;

  logic [23:0] gate_cnt;
  logic [23:0] next_gate_cnt;
  logic [15:0] edge_cnt;
  logic [15:0] next_edge_cnt;
  logic        pulse_d;
  logic        next_pulse_d;
  logic [15:0] freq_hz;
  logic [15:0] next_freq_hz;
  logic [15:0] percent;
  logic [15:0] next_percent;
  logic        update;
  logic        next_update;
  logic [35:0] quotient;
  logic [19:0] hz_wide;

  // ==========================================================================
  // Gated edge counter
  // ==========================================================================
  always_comb
  begin
    next_pulse_d  = i_pulse_sync;
    next_gate_cnt = gate_cnt + 24'h00_0001;
    next_edge_cnt = edge_cnt;
    next_freq_hz  = freq_hz;
    next_percent  = percent;
    next_update   = 1'b0;
    hz_wide       = 20'h0_0000;
    quotient      = 36'h0_0000_0000;
    if (i_pulse_sync && !pulse_d && edge_cnt != 16'hFFFF)
    begin
      next_edge_cnt = edge_cnt + 16'h0001;
    end
    if (gate_cnt == 24'(GATE_CYCLES - 1))
    begin
      next_gate_cnt = 24'h00_0000;
      // An edge in the closing cycle still belongs to this gate, so none is lost between gates.
      hz_wide       = 20'(next_edge_cnt) * 20'(GATES_PER_SEC);
      next_edge_cnt = 16'h0000;
      next_freq_hz  = (hz_wide > 20'h0_FFFF) ? 16'hFFFF : hz_wide[15:0];
      // scale to programmed frequency.
      // The scale is the live setting, so a change while running lands at the next gate.
      quotient      = (36'(hz_wide) << 14) / 36'(i_scale_hz);
      next_percent  = (quotient > 36'h0_0000_FFFF) ? 16'hFFFF : quotient[15:0];
      next_update   = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      gate_cnt <= 24'h00_0000;
      edge_cnt <= 16'h0000;
      pulse_d  <= 1'b0;
      freq_hz  <= 16'h0000;
      percent  <= 16'h0000;
      update   <= 1'b0;
    end
    else
    begin
      gate_cnt <= next_gate_cnt;
      edge_cnt <= next_edge_cnt;
      pulse_d  <= next_pulse_d;
      freq_hz  <= next_freq_hz;
      percent  <= next_percent;
      update   <= next_update;
    end
  end

  assign o_freq_hz     = freq_hz;
  assign o_percent_q14 = percent;
  assign o_update      = update;

endmodule // pulse_scaler

`default_nettype wire

// [rtl/freq_ref_selector.sv]
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "freq_ref_cfg.svh"

module freq_ref_selector
  import freq_ref_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = `GATE_CYCLES
)(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic [11:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [11:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic [15:0] i_analog_in_first,
  input  wire logic [15:0] i_analog_in_second,
  input  wire logic [15:0] i_analog_in_third,
  input  wire logic        i_pulse_train_pin,
  input  wire logic        i_step1,
  input  wire logic        i_step2,
  input  wire logic        i_step3,
  input  wire logic        i_jog_sel,
  output logic [15:0]      o_freq_ref,
  output logic [15:0]      o_pid_feedback,
  output logic [15:0]      o_pid_target,
  output logic             o_ref_update
);

  // ==========================================================================
  // Storage and state
  // ==========================================================================
  logic [2:0]   freq_ref_source_sel;
  logic [1:0]   pulse_input_func_sel;
  logic [15:0]  pulse_input_scale;
  ain_cfg_t     ain_cfg;
  logic [15:0]  operator_ref;
  logic [15:0]  serial_ref;
  logic [15:0]  option_ref;
  logic [15:0]  jog_freq_value;
  logic [15:0]  multi_ref [16];
  logic [3:0]   pin_s1;
  logic [3:0]   pin_s2;
  logic [1:0]   pulse_s;
  step_inputs_t steps;
  logic [15:0]  pulse_freq;
  logic [15:0]  pulse_pct;
  logic         pulse_update;
  logic [15:0]  freq_ref;
  logic [15:0]  pid_fb;
  logic [15:0]  pid_tgt;
  logic [15:0]  next_freq_ref;
  logic [15:0]  next_pid_fb;
  logic [15:0]  next_pid_tgt;
  logic         ref_update;
  logic         wr_fire;
  logic         rd_fire;
  logic         aw_held;
  logic         w_held;
  logic [11:0]  aw_addr;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic         bvalid;
  logic [1:0]   bresp;
  logic         rvalid;
  logic [1:0]   rresp;
  logic [31:0]  rdata;
  logic [31:0]  rd_word;
  logic         rd_ok;
  logic         wr_ok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++)
    begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function automatic logic is_multi(input logic [11:0] a);
    is_multi = (a[11:6] == 6'(`OFS_MULTI_BASE >> 6)) && (a[1:0] == 2'b00);
  endfunction

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // selection inputs sampled synchronously.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pin_s1  <= 4'h0;
      pin_s2  <= 4'h0;
      pulse_s <= 2'b00;
    end
    else
    begin
      pin_s1  <= {i_step1, i_step2, i_step3, i_jog_sel};
      pin_s2  <= pin_s1;
      pulse_s <= {pulse_s[0], i_pulse_train_pin};
    end
  end
  assign steps = step_inputs_t'(pin_s2);

  pulse_scaler #(
    .GATE_CYCLES (GATE_CYCLES)
  ) u_pulse_scaler (
    .i_clk         (i_clk),
    .i_arst_n      (i_arst_n),
    .i_pulse_sync  (pulse_s[1]),
    .i_scale_hz    (pulse_input_scale),
    .o_freq_hz     (pulse_freq),
    .o_percent_q14 (pulse_pct),
    .o_update      (pulse_update)
  );

  // ==========================================================================
  // AXI4-Lite slave
  // ==========================================================================
  assign wr_fire = (aw_held || i_awvalid) && (w_held || i_wvalid) && !bvalid;

  always_comb
  begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    if (is_multi(i_araddr))
    begin
      rd_word = {16'h0000, multi_ref[i_araddr[5:2]]};
    end
    else
    begin
      unique case (i_araddr)
        `OFS_SOURCE_SEL:   rd_word = {29'h0, freq_ref_source_sel};
        `OFS_PULSE_FUNC:   rd_word = {30'h0, pulse_input_func_sel};
        `OFS_PULSE_SCALE:  rd_word = {16'h0000, pulse_input_scale};
        `OFS_AIN_CFG:      rd_word = {11'h0, ain_cfg.third_func, 3'h0, ain_cfg.second_func,
                                      6'h0, ain_cfg.second_level};
        `OFS_OPERATOR_REF: rd_word = {16'h0000, operator_ref};
        `OFS_SERIAL_REF:   rd_word = {16'h0000, serial_ref};
        `OFS_OPTION_REF:   rd_word = {16'h0000, option_ref};
        `OFS_JOG_REF:      rd_word = {16'h0000, jog_freq_value};
        `OFS_FREQ_REF:     rd_word = {16'h0000, freq_ref};
        `OFS_PULSE_FREQ:   rd_word = {16'h0000, pulse_freq};
        `OFS_STATUS:       rd_word = {28'h0, steps};
        default:           rd_ok   = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'b00;
      rvalid  <= 1'b0;
      rresp   <= 2'b00;
      rdata   <= 32'h0000_0000;
    end
    else
    begin
      if (i_awvalid && !aw_held && !bvalid)
      begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && !w_held && !bvalid)
      begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (aw_held && w_held && !bvalid)
      begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_ok ? 2'b00 : 2'b10;
      end
      else if (bvalid && i_bready)
      begin
        bvalid <= 1'b0;
      end
      if (i_arvalid && !rvalid)
      begin
        rvalid <= 1'b1;
        rdata  <= rd_word;
        rresp  <= rd_ok ? 2'b00 : 2'b10;
      end
      else if (rvalid && i_rready)
      begin
        rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Settings
  // ==========================================================================
  // Out-of-range writes are refused with SLVERR and leave the setting as it was.
  logic [31:0] wv;
  assign wv = merge(32'h0000_0000, w_data, w_strb);
  always_comb
  begin
    wr_ok = 1'b1;
    if (!is_multi(aw_addr))
    begin
      unique case (aw_addr)
        `OFS_SOURCE_SEL:   wr_ok = wv[2:0] <= `MAX_SOURCE_SEL && wv[31:3] == 29'h0;
        `OFS_PULSE_FUNC:   wr_ok = wv[1:0] <= `MAX_PULSE_FUNC && wv[31:2] == 30'h0;
        `OFS_PULSE_SCALE:  wr_ok = wv[15:0] >= `MIN_PULSE_SCALE &&
                                   wv[15:0] <= `MAX_PULSE_SCALE;
        `OFS_AIN_CFG, `OFS_OPERATOR_REF, `OFS_SERIAL_REF,
        `OFS_OPTION_REF, `OFS_JOG_REF: wr_ok = 1'b1;
        default:           wr_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      freq_ref_source_sel  <= `RST_SOURCE_SEL;
      pulse_input_func_sel <= `RST_PULSE_FUNC;
      pulse_input_scale    <= `RST_PULSE_SCALE;
      ain_cfg              <= {`RST_AIN_SECOND_LVL, `RST_AIN_SECOND_FN, `RST_AIN_THIRD_FN};
      operator_ref         <= 16'h0000;
      serial_ref           <= 16'h0000;
      option_ref           <= 16'h0000;
      jog_freq_value       <= 16'h0000;
      for (int i = 0; i < 16; i++)
      begin
        multi_ref[i] <= 16'h0000;
      end
    end
    else if (aw_held && w_held && !bvalid && wr_ok)
    begin
      if (is_multi(aw_addr))
      begin
        multi_ref[aw_addr[5:2]] <= wv[15:0];
      end
      else
      begin
        unique case (aw_addr)
          `OFS_SOURCE_SEL:   freq_ref_source_sel  <= wv[2:0];
          `OFS_PULSE_FUNC:   pulse_input_func_sel <= wv[1:0];
          `OFS_PULSE_SCALE:  pulse_input_scale    <= wv[15:0];
          `OFS_AIN_CFG:      ain_cfg <= {wv[1:0], wv[12:8], wv[20:16]};
          `OFS_OPERATOR_REF: operator_ref   <= wv[15:0];
          `OFS_SERIAL_REF:   serial_ref     <= wv[15:0];
          `OFS_OPTION_REF:   option_ref     <= wv[15:0];
          `OFS_JOG_REF:      jog_freq_value <= wv[15:0];
          default:           operator_ref   <= operator_ref;
        endcase
      end
    end
  end

  // ==========================================================================
  // Reference selection
  // ==========================================================================
  logic [15:0] master_ref;
  logic [16:0] sum_ref;
  logic [3:0]  step_idx;
  always_comb
  begin
    // first analog, second added when configured.
    // current master relies on first held at zero.
    sum_ref    = {1'b0, i_analog_in_first};
    if (ain_cfg.second_func == `AIN_FN_ADD_FIRST)
    begin
      sum_ref = sum_ref + {1'b0, i_analog_in_second};
    end
    master_ref = sum_ref[16] ? 16'hFFFF : sum_ref[15:0];
    // binary index, step 1 as LSB.
    step_idx   = {1'b0, steps.step3, steps.step2, steps.step1};
    // only the routed use keeps a value.
    next_pid_fb  = (pulse_input_func_sel == 2'h1) ? pid_fb : 16'h0000;
    next_pid_tgt = (pulse_input_func_sel == 2'h2) ? pid_tgt : 16'h0000;
    unique case (freq_ref_source_sel)
      3'h0:    next_freq_ref = operator_ref;
      3'h1:    next_freq_ref = master_ref;
      3'h2:    next_freq_ref = serial_ref;
      3'h3:    next_freq_ref = option_ref;
      3'h4:    next_freq_ref = (pulse_input_func_sel == 2'h0) ? pulse_pct : 16'h0000;
      default: next_freq_ref = freq_ref;
    endcase
    // only when third terminal is auxiliary.
    if (freq_ref_source_sel == 3'h1 && ain_cfg.third_func == `AIN_FN_AUX && steps.step1 &&
        !steps.step2 && !steps.step3)
    begin
      next_freq_ref = i_analog_in_third;
    end
    // stored references beyond the first step.
    else if (step_idx != 4'h0)
    begin
      next_freq_ref = multi_ref[step_idx];
    end
    if (steps.jog)
    begin
      next_freq_ref = jog_freq_value;
    end
    if (pulse_update && pulse_input_func_sel == 2'h1)
    begin
      next_pid_fb = pulse_pct;
    end
    if (pulse_update && pulse_input_func_sel == 2'h2)
    begin
      next_pid_tgt = pulse_pct;
    end
  end

  // applied at the next reference update.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      freq_ref   <= 16'h0000;
      pid_fb     <= 16'h0000;
      pid_tgt    <= 16'h0000;
      ref_update <= 1'b0;
    end
    else
    begin
      freq_ref   <= next_freq_ref;
      pid_fb     <= next_pid_fb;
      pid_tgt    <= next_pid_tgt;
      ref_update <= 1'b1;
    end
  end

  assign o_awready      = i_awvalid && !aw_held && !bvalid;
  assign o_wready       = i_wvalid && !w_held && !bvalid;
  assign o_bvalid       = bvalid;
  assign o_bresp        = bresp;
  assign o_arready      = i_arvalid && !rvalid;
  assign o_rvalid       = rvalid;
  assign o_rdata        = rdata;
  assign o_rresp        = rresp;
  assign o_freq_ref     = freq_ref;
  assign o_pid_feedback = pid_fb;
  assign o_pid_target   = pid_tgt;
  assign o_ref_update   = ref_update;

endmodule // freq_ref_selector

`default_nettype wire

// [sim/freq_ref_selector_asserts.sv]
`timescale 1ns/1ps
`default_nettype none

module freq_ref_selector_asserts (
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_awvalid,
  input wire logic        i_wvalid,
  input wire logic        i_arvalid,
  input wire logic        i_bready,
  input wire logic        i_rready,
  input wire logic        o_awready,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic [1:0]  o_rresp,
  input wire logic [31:0] o_rdata,
  input wire logic [15:0] o_pid_feedback,
  input wire logic [15:0] o_pid_target,
  input wire logic        o_ref_update
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // ==========================================================================
  // Output relations
  // ==========================================================================
  AST_REF_UPDATE: assert property ($past(i_arst_n) |-> o_ref_update)
    else $error("reference update not running");
  AST_PID_ONE_USE: assert property (!(o_pid_feedback != 16'h0 && o_pid_target != 16'h0))
    else $error("pulse train routed to two uses");
  AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read response dropped or changed");
  AST_R_AFTER_AR: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  AST_R_ORIGIN: assert property ($rose(o_rvalid) |-> $past(i_arvalid))
    else $error("read answer without request");
  AST_RERR_ZERO: assert property (o_rvalid && o_rresp == 2'h2 |-> o_rdata == 32'h0000_0000)
    else $error("refused read carries data");
  AST_B_WITHIN: assert property (i_awvalid && o_awready && i_wvalid && o_wready
    |-> ##[1:3] o_bvalid)
    else $error("write answer late");
endmodule // freq_ref_selector_asserts

bind freq_ref_selector freq_ref_selector_asserts u_chk (
  .i_clk, .i_arst_n, .i_awvalid, .i_wvalid, .i_arvalid, .i_bready, .i_rready, .o_awready,
  .o_wready, .o_bvalid, .o_arready, .o_rvalid, .o_rresp, .o_rdata, .o_pid_feedback,
  .o_pid_target, .o_ref_update
);

`default_nettype wire

// [sim/ref_source_model.sv]
`timescale 1ns/1ps
`default_nettype none

module ref_source_model (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_current,
  input  wire logic        i_pulse_en,
  input  wire logic [15:0] i_level_first,
  input  wire logic [15:0] i_level_second,
  input  wire logic [15:0] i_level_third,
  output logic      [15:0] o_first,
  output logic      [15:0] o_second,
  output logic      [15:0] o_third,
  output logic             o_pulse
);
  logic [2:0] cnt;

  // ==========================================================================
  // Terminal levels and pulse source
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_first  <= 16'h0;
      o_second <= 16'h0;
      o_third  <= 16'h0;
      o_pulse  <= 1'b0;
      cnt      <= 3'h0;
    end
    else
    begin
      o_first  <= i_current ? 16'h0 : i_level_first;
      o_second <= i_level_second;
      o_third  <= i_level_third;
      cnt      <= cnt + 3'h1;
      // The pin rests low between bursts so no stale level counts as an edge.
      o_pulse  <= i_pulse_en & cnt[2];
    end
  end
endmodule // ref_source_model

`default_nettype wire

// [sim/freq_ref_selector_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module freq_ref_selector_tb;
  import freq_ref_pkg::*;
  logic        i_clk = 0, i_arst_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic        i_arvalid = 0, i_rready = 0, i_step1 = 0, i_step2 = 0, i_step3 = 0;
  logic        i_jog_sel = 0, cur = 0, pen = 0, pin;
  logic [11:0] i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0, o_rdata, q;
  logic [3:0]  i_wstrb = 0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_ref_update;
  logic [1:0]  o_bresp, o_rresp, r;
  logic [15:0] o_freq_ref, o_pid_feedback, o_pid_target, a1, a2, a3;
  logic [15:0] l1 = 0, l2 = 0, l3 = 0, op, ser, opt, jog, pexp, mult [16];
  // The bench gate is 1000 cycles and the model pulses every 8, reported as ten gates a second.
  localparam int pulse_hz = 1000 / 8 * 10;
  logic [15:0] scl [4] = '{16'd999, 16'd1000, 16'd32000, 16'd32001};
  logic [2:0]  src;
  logic [4:0]  sfn, tfn;
  int          fails = 0, n_checks = 0, seed = 52359, cyc = 0;

  initial forever #50 i_clk = ~i_clk;

  freq_ref_selector #(.GATE_CYCLES(1000)) dut (.i_clk, .i_arst_n, .i_awaddr, .i_awvalid,
    .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_analog_in_first(a1),
    .i_analog_in_second(a2), .i_analog_in_third(a3), .i_pulse_train_pin(pin), .i_step1,
    .i_step2, .i_step3, .i_jog_sel, .o_freq_ref, .o_pid_feedback, .o_pid_target,
    .o_ref_update);

  ref_source_model src_m (.i_clk, .i_arst_n, .i_current(cur), .i_pulse_en(pen),
    .i_level_first(l1), .i_level_second(l2), .i_level_third(l3), .o_first(a1),
    .o_second(a2), .o_third(a3), .o_pulse(pin));

  // ==========================================================================
  // Checking and bus tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Each request stands until the rising edge that sees its ready high, and is dropped there.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic ad, dd, ar, k;
    k = 0;
    @(posedge i_clk);
    i_awaddr <= a; i_awvalid <= w; i_wdata <= d; i_wstrb <= 4'hF; i_wvalid <= w;
    i_bready <= w; i_araddr <= a; i_arvalid <= !w; i_rready <= !w;
    while (!k)
    begin
      @(posedge i_clk);
      ad = i_awvalid & o_awready;
      dd = i_wvalid & o_wready;
      ar = i_arvalid & o_arready;
      k = w ? (i_bready & o_bvalid) : (i_rready & o_rvalid);
      r = w ? o_bresp : o_rresp;
      q = o_rdata;
      if (ad) i_awvalid <= 0;
      if (dd) i_wvalid <= 0;
      if (ar) i_arvalid <= 0;
      if (k) {i_bready, i_rready} <= 2'b00;
    end
  endtask

  function automatic logic [15:0] expect_ref();
    logic [2:0] idx;
    idx = {i_step3, i_step2, i_step1};
    if (i_jog_sel) return jog;
    if (idx == 3'd1 && tfn == 5'h02 && src == 3'd1) return l3;
    if (idx != 3'd0) return mult[idx];
    case (src)
      3'd0: return op;
      3'd1: return (cur ? 16'h0 : l1) + (sfn == 5'h00 ? l2 : 16'h0);
      3'd2: return ser;
      3'd3: return opt;
      3'd4: return pexp;
      default: return 16'h0;
    endcase
  endfunction

  function automatic logic [15:0] pulse_pct(input int hz, input int scale);
    return 16'((hz * 16384) / scale);
  endfunction

  task automatic settle();
    repeat (5) @(posedge i_clk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      fails++;
      complete_run();
    end
  end

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1;
    src = 3'd1; sfn = 5'h1F; tfn = 5'h1F;
    bus(0, 12'h000, 0); check(q, 32'h0000_0001);
    bus(0, 12'h004, 0); check(q, 32'h0000_0000);
    bus(0, 12'h008, 0); check(q, 32'h0000_05A0);
    bus(0, 12'h00C, 0); check(q, 32'h001F_1F00);
    bus(0, 12'h0FC, 0); check({r, q[29:0]}, 32'h8000_0000);
    bus(1, 12'h000, 32'h0000_0005); check(r, 2'h2);
    bus(1, 12'h004, 32'h0000_0003); check(r, 2'h2);
    for (int i = 0; i < 4; i++)
    begin
      bus(1, 12'h008, {16'h0, scl[i]}); check(r, (i == 0 || i == 3) ? 2'h2 : 2'h0);
    end
    bus(0, 12'h008, 0); check(q, 32'h0000_7D00);
    $display("test settings done");
    for (int i = 0; i < 4; i++)
    begin
      op = 16'($random(seed)); ser = 16'($random(seed)); opt = 16'($random(seed));
      l1 <= 16'($random(seed)) & 16'h3FFF; l2 <= 16'($random(seed)) & 16'h3FFF;
      bus(1, 12'h010, {16'h0, op}); bus(1, 12'h014, {16'h0, ser});
      bus(1, 12'h018, {16'h0, opt});
      src = 3'(i);
      bus(1, 12'h000, {29'h0, src}); settle(); check(o_freq_ref, expect_ref());
    end
    src = 3'd1; sfn = 5'h00; cur <= 1;
    bus(1, 12'h000, 32'h0000_0001);
    bus(1, 12'h00C, 32'h001F_0002); settle(); check(o_freq_ref, expect_ref());
    cur <= 0; settle(); check(o_freq_ref, expect_ref());
    tfn = 5'h02; l3 <= 16'($random(seed));
    // third terminal auxiliary, step 1 assigned
    bus(1, 12'h00C, 32'h0002_0002); i_step1 <= 1; settle(); check(o_freq_ref, expect_ref());
    i_step1 <= 0; settle(); check(o_freq_ref, expect_ref());
    $display("test analog done");
    jog = 16'($random(seed)); bus(1, 12'h01C, {16'h0, jog});
    for (int i = 0; i < 16; i++)
    begin
      mult[i] = 16'($random(seed)); bus(1, 12'h040 + 12'(4 * i), {16'h0, mult[i]});
    end
    for (int i = 0; i < 16; i++)
    begin
      bus(0, 12'h040 + 12'(4 * i), 0); check(q, {16'h0, mult[i]});
    end
    for (int i = 0; i < 16; i++)
    begin
      {i_jog_sel, i_step3, i_step2, i_step1} <= 4'(i); settle();
      check(o_freq_ref, expect_ref());
    end
    bus(0, 12'h088, 0); check(q, 32'h0000_000F);
    $display("test steps done");
    {i_jog_sel, i_step3, i_step2, i_step1} <= 4'h0; pen <= 1; src = 3'd4;
    bus(1, 12'h004, 32'h0000_0000); check(r, 2'h0);
    bus(1, 12'h000, 32'h0000_0004); repeat (2100) @(posedge i_clk);
    pexp = pulse_pct(pulse_hz, 32000);
    bus(0, 12'h084, 0); check(q, 32'(pulse_hz));
    check(o_freq_ref, expect_ref());
    for (int f = 1; f < 3; f++)
    begin
      bus(1, 12'h004, 32'(f)); repeat (1100) @(posedge i_clk);
      check(o_freq_ref, 32'h0000_0000);
      check(o_pid_feedback, (f == 1) ? pexp : 16'h0000);
      check(o_pid_target, (f == 2) ? pexp : 16'h0000);
    end
    $display("test pulse done");
    complete_run();
  end
endmodule // freq_ref_selector_tb

`default_nettype wire
